// file: rtl/pcrb_irq_detect.sv
// Pad input synchroniser and per-pad edge or level interrupt detector.
`timescale 1ns/1ps
module pcrb_irq_detect (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire pcrb_pkg::pcrb_pad_t padIn,
  pcrb_irq_if.det irqBus
);
  import pcrb_pkg::*;

  typedef struct packed {
    pcrb_pad_t sync1;
    pcrb_pad_t sync2;
    pcrb_pad_t prev;
    pcrb_pad_t raw;
  } pcrb_det_s;

  pcrb_det_s st;
  pcrb_det_s next_st;
  pcrb_pad_t rise;
  pcrb_pad_t fall;
  pcrb_pad_t edgeHit;
  pcrb_pad_t levelHit;
  pcrb_pad_t hit;

  // Only the second stage feeds any logic, so the first stage may settle freely.
  always_comb begin
    next_st = st;
    next_st.sync1 = padIn;
    next_st.sync2 = st.sync1;
    next_st.prev = st.sync2;
    rise = st.sync2 & ~st.prev;
    fall = ~st.sync2 & st.prev;
    // Both-edge mode ignores polarity entirely.
    edgeHit = (irqBus.bothEdge & (rise | fall))
            | (~irqBus.bothEdge & irqBus.polarityHigh & rise)
            | (~irqBus.bothEdge & ~irqBus.polarityHigh & fall);
    levelHit = (irqBus.polarityHigh & st.sync2) | (~irqBus.polarityHigh & ~st.sync2);
    hit = (irqBus.senseLevel & levelHit) | (~irqBus.senseLevel & edgeHit);
    // A new event wins over a clear in the same cycle; a held level re-arms every cycle.
    next_st.raw = (st.raw & ~irqBus.clearBits) | hit;
  end

  // State register.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign irqBus.padSync = st.sync2;
  assign irqBus.rawStatus = st.raw;

endmodule // pcrb_irq_detect

// file: rtl/pcrb_irq_if.sv
// Interface between the register bank and the pad interrupt detector.
`timescale 1ns/1ps
interface pcrb_irq_if;
  pcrb_pkg::pcrb_pad_t padSync;
  pcrb_pkg::pcrb_pad_t senseLevel;
  pcrb_pkg::pcrb_pad_t bothEdge;
  pcrb_pkg::pcrb_pad_t polarityHigh;
  pcrb_pkg::pcrb_pad_t clearBits;
  pcrb_pkg::pcrb_pad_t rawStatus;

  modport ctrl(output senseLevel, output bothEdge, output polarityHigh, output clearBits,
               input padSync, input rawStatus);
  modport det(input senseLevel, input bothEdge, input polarityHigh, input clearBits,
              output padSync, output rawStatus);
endinterface

// file: rtl/pcrb_pkg.sv
// Package with the register map, reset values and field layout of the pad control bank.
package pcrb_pkg;

  localparam int PAD_COUNT = 15;
  localparam int FUNC_WIDTH = 3;
  localparam int FUNC_STRIDE = 4;
  localparam int LOW_PADS = 8;
  localparam int CAP_COUNT = 4;
  localparam int CAP_WIDTH = 8;

  typedef logic [PAD_COUNT-1:0] pcrb_pad_t;
  typedef logic [31:0] pcrb_word_t;
  typedef logic [11:0] pcrb_addr_t;
  typedef logic [FUNC_WIDTH-1:0] pcrb_func_t;

  // Byte offsets of every register on the bus.
  localparam pcrb_addr_t OFS_OUTPUT_DATA = 12'h000;
  localparam pcrb_addr_t OFS_DIRECTION = 12'h004;
  localparam pcrb_addr_t OFS_PULL_ENABLE = 12'h008;
  localparam pcrb_addr_t OFS_DRIVE_STRENGTH = 12'h00C;
  localparam pcrb_addr_t OFS_SENSE_SELECT = 12'h010;
  localparam pcrb_addr_t OFS_BOTH_EDGE = 12'h014;
  localparam pcrb_addr_t OFS_POLARITY = 12'h018;
  localparam pcrb_addr_t OFS_IRQ_MASK = 12'h01C;
  localparam pcrb_addr_t OFS_RAW_STATUS = 12'h020;
  localparam pcrb_addr_t OFS_MASKED_STATUS = 12'h024;
  localparam pcrb_addr_t OFS_IRQ_CLEAR = 12'h028;
  localparam pcrb_addr_t OFS_FUNC_LOW = 12'h02C;
  localparam pcrb_addr_t OFS_FUNC_HIGH = 12'h030;
  localparam pcrb_addr_t OFS_BIT_SET = 12'h03C;
  localparam pcrb_addr_t OFS_BIT_CLEAR = 12'h040;
  localparam pcrb_addr_t OFS_CAPTURE_SEL = 12'h044;

  // Reset values of the writable registers.
  localparam pcrb_word_t RST_ZERO = 32'h00000000;
  localparam pcrb_word_t RST_PULL_ENABLE = 32'h003FFFFF;
  localparam pcrb_word_t RST_FUNC_HIGH = 32'h00000110;

  // Pad function codes.
  localparam pcrb_func_t FUNC_GPIO = 3'h0;
  localparam pcrb_func_t FUNC_ALT_ONE = 3'h1;
  localparam pcrb_func_t FUNC_ALT_ZERO = 3'h4;
  localparam pcrb_func_t FUNC_ALT_TWO = 3'h5;

  // Returns the function code of one pad from the two function registers.
  function automatic pcrb_func_t padCode(input pcrb_word_t lo, input pcrb_word_t hi, input int idx);
    pcrb_func_t code;
    code = FUNC_GPIO;
    if (idx < LOW_PADS) begin
      code = lo[idx*FUNC_STRIDE +: FUNC_WIDTH];
    end else begin
      code = hi[(idx-LOW_PADS)*FUNC_STRIDE +: FUNC_WIDTH];
    end
    return code;
  endfunction

endpackage

// file: rtl/pcrb_top.sv
// APB register bank that controls fifteen general-purpose pads, their interrupts and routing.
//
// Behaviour
// - A GPIO pad set as output drives the stored output data bit.
// - Reading output data returns the synchronised pad levels, not stored values.
// - Direction bit: 0 input, 1 output; every pad resets to input.
// - Pull enable bit: 0 pull off, 1 pull on; documented reset value.
// - Drive strength bit: 0 low drive, 1 high drive; resets to low.
// - Sense bit: 0 edge detection, 1 level detection.
// - Both-edge bit: 0 single edge, 1 both rising and falling edges.
// - Polarity bit: 0 falling or low, 1 rising or high.
// - Pads zero to seven take three-bit function codes, reset to GPIO.
// - Pads eight to fourteen likewise; pads nine and ten reset to first serial.
// - Writing 1 to the set port sets output data bits of GPIO pads.
// - Writing 1 to the clear port clears output data bits of GPIO pads.
// - Capture routing picks the pad feeding each timer capture input; resets zero.
// - Interrupt mask bit: 0 blocks, 1 allows; resets all blocked.
// - Read-only masked status shows pending enabled interrupts per pad.
// - Writing 1 to interrupt clear clears that pending bit unless a same-cycle event or a held level sets it again; 0 does nothing.
`timescale 1ns/1ps
module pcrb_top (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire pcrb_pkg::pcrb_addr_t paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire pcrb_pkg::pcrb_word_t pwdata,
  output pcrb_pkg::pcrb_word_t prdata,
  output logic pready,
  output logic pslverr,
  input wire pcrb_pkg::pcrb_pad_t padIn,
  output pcrb_pkg::pcrb_pad_t padOut,
  output pcrb_pkg::pcrb_pad_t padOutEnableN,
  output pcrb_pkg::pcrb_pad_t padPullEnable,
  output pcrb_pkg::pcrb_pad_t padHighDrive,
  output logic [pcrb_pkg::PAD_COUNT*pcrb_pkg::FUNC_WIDTH-1:0] padFunction,
  output logic [pcrb_pkg::CAP_COUNT-1:0] timerCapture,
  output logic irq
);
  import pcrb_pkg::*;

  typedef struct packed {
    pcrb_word_t outData;
    pcrb_word_t direction;
    pcrb_word_t pullEnable;
    pcrb_word_t driveStrength;
    pcrb_word_t senseSelect;
    pcrb_word_t bothEdge;
    pcrb_word_t polarity;
    pcrb_word_t irqMask;
    pcrb_word_t funcLow;
    pcrb_word_t funcHigh;
    pcrb_word_t captureSel;
    pcrb_word_t readData;
    logic readError;
  } pcrb_regs_s;

  pcrb_regs_s st;
  pcrb_regs_s next_st;
  pcrb_irq_if irqBus();
  pcrb_pad_t gpioMask;
  pcrb_pad_t maskedStatus;
  pcrb_word_t gpioWord;
  logic wrAccess;
  logic rdSetup;

  // Tells whether an offset holds a register; unmapped offsets answer with an error.
  function automatic logic addrMapped(input pcrb_addr_t a);
    logic hitAddr;
    hitAddr = 1'b0;
    unique case (a)
      OFS_OUTPUT_DATA, OFS_DIRECTION, OFS_PULL_ENABLE, OFS_DRIVE_STRENGTH,
      OFS_SENSE_SELECT, OFS_BOTH_EDGE, OFS_POLARITY, OFS_IRQ_MASK,
      OFS_RAW_STATUS, OFS_MASKED_STATUS, OFS_IRQ_CLEAR, OFS_FUNC_LOW,
      OFS_FUNC_HIGH, OFS_BIT_SET, OFS_BIT_CLEAR, OFS_CAPTURE_SEL: begin
        hitAddr = 1'b1;
      end
      default: begin
        hitAddr = 1'b0;
      end
    endcase
    return hitAddr;
  endfunction

  // Read multiplexer; write-only ports read back as zero.
  function automatic pcrb_word_t readMux(input pcrb_regs_s r, input pcrb_addr_t a,
                                         input pcrb_pad_t pads, input pcrb_pad_t raw,
                                         input pcrb_pad_t masked);
    pcrb_word_t d;
    d = RST_ZERO;
    unique case (a)
      OFS_OUTPUT_DATA: begin
        d = {{(32-PAD_COUNT){1'b0}}, pads};
      end
      OFS_DIRECTION: begin
        d = r.direction;
      end
      OFS_PULL_ENABLE: begin
        d = r.pullEnable;
      end
      OFS_DRIVE_STRENGTH: begin
        d = r.driveStrength;
      end
      OFS_SENSE_SELECT: begin
        d = r.senseSelect;
      end
      OFS_BOTH_EDGE: begin
        d = r.bothEdge;
      end
      OFS_POLARITY: begin
        d = r.polarity;
      end
      OFS_IRQ_MASK: begin
        d = r.irqMask;
      end
      OFS_RAW_STATUS: begin
        d = {{(32-PAD_COUNT){1'b0}}, raw};
      end
      OFS_MASKED_STATUS: begin
        d = {{(32-PAD_COUNT){1'b0}}, masked};
      end
      OFS_FUNC_LOW: begin
        d = r.funcLow;
      end
      OFS_FUNC_HIGH: begin
        d = r.funcHigh;
      end
      OFS_CAPTURE_SEL: begin
        d = r.captureSel;
      end
      default: begin
        d = RST_ZERO;
      end
    endcase
    return d;
  endfunction

  // Which pads are currently in general-purpose function.
  always_comb begin
    for (int i = 0; i < PAD_COUNT; i++) begin
      gpioMask[i] = (padCode(st.funcLow, st.funcHigh, i) == FUNC_GPIO);
    end
    gpioWord = {{(32-PAD_COUNT){1'b0}}, gpioMask};
  end

  // Bus phases: writes land at the end of the access phase, read data is latched in setup.
  assign wrAccess = psel & penable & pwrite;
  assign rdSetup = psel & ~penable;

  // Next register state from bus writes; one process covers every writable register.
  always_comb begin
    next_st = st;
    if (rdSetup) begin
      next_st.readData = pwrite ? RST_ZERO
                                : readMux(st, paddr, irqBus.padSync, irqBus.rawStatus, maskedStatus);
      next_st.readError = ~addrMapped(paddr);
    end
    if (wrAccess) begin
      unique case (paddr)
        OFS_OUTPUT_DATA: begin
          next_st.outData = pwdata;
        end
        OFS_DIRECTION: begin
          next_st.direction = pwdata;
        end
        OFS_PULL_ENABLE: begin
          next_st.pullEnable = pwdata;
        end
        OFS_DRIVE_STRENGTH: begin
          next_st.driveStrength = pwdata;
        end
        OFS_SENSE_SELECT: begin
          next_st.senseSelect = pwdata;
        end
        OFS_BOTH_EDGE: begin
          next_st.bothEdge = pwdata;
        end
        OFS_POLARITY: begin
          next_st.polarity = pwdata;
        end
        OFS_IRQ_MASK: begin
          next_st.irqMask = pwdata;
        end
        OFS_FUNC_LOW: begin
          next_st.funcLow = pwdata;
        end
        OFS_FUNC_HIGH: begin
          next_st.funcHigh = pwdata;
        end
        // Set and clear touch only GPIO pads, so an alternate pad's stored bit is safe.
        OFS_BIT_SET: begin
          next_st.outData = st.outData | (pwdata & gpioWord);
        end
        OFS_BIT_CLEAR: begin
          next_st.outData = st.outData & ~(pwdata & gpioWord);
        end
        OFS_CAPTURE_SEL: begin
          next_st.captureSel = pwdata;
        end
        default: begin
          next_st.outData = st.outData;
        end
      endcase
    end
  end

  // Register bank with its documented reset values.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st.outData <= RST_ZERO;
      st.direction <= RST_ZERO;
      st.pullEnable <= RST_PULL_ENABLE;
      st.driveStrength <= RST_ZERO;
      st.senseSelect <= RST_ZERO;
      st.bothEdge <= RST_ZERO;
      st.polarity <= RST_ZERO;
      st.irqMask <= RST_ZERO;
      st.funcLow <= RST_ZERO;
      st.funcHigh <= RST_FUNC_HIGH;
      st.captureSel <= RST_ZERO;
      st.readData <= RST_ZERO;
      st.readError <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // Interrupt clear is a one-cycle strobe; the detector lets a same-cycle event win.
  assign irqBus.clearBits = (wrAccess && paddr == OFS_IRQ_CLEAR) ? pwdata[PAD_COUNT-1:0] : '0;
  assign irqBus.senseLevel = st.senseSelect[PAD_COUNT-1:0];
  assign irqBus.bothEdge = st.bothEdge[PAD_COUNT-1:0];
  assign irqBus.polarityHigh = st.polarity[PAD_COUNT-1:0];

  // Edge and level detection with the pad synchroniser.
  pcrb_irq_detect detector (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .padIn(padIn),
    .irqBus(irqBus.det)
  );

  // Masked status and the single level interrupt.
  assign maskedStatus = irqBus.rawStatus & st.irqMask[PAD_COUNT-1:0];
  assign irq = |maskedStatus;

  // Pad drive: released unless the pad is GPIO and set as output.
  assign padOut = st.outData[PAD_COUNT-1:0];
  assign padOutEnableN = ~(gpioMask & st.direction[PAD_COUNT-1:0]);
  assign padPullEnable = st.pullEnable[PAD_COUNT-1:0];
  assign padHighDrive = st.driveStrength[PAD_COUNT-1:0];

  // Function codes go to the pad multiplexer that hosts the serial alternates.
  always_comb begin
    for (int i = 0; i < PAD_COUNT; i++) begin
      padFunction[i*FUNC_WIDTH +: FUNC_WIDTH] = padCode(st.funcLow, st.funcHigh, i);
    end
  end

  // Capture routing; an index past the last pad gives a quiet low input.
  always_comb begin
    for (int k = 0; k < CAP_COUNT; k++) begin
      timerCapture[k] = 1'b0;
      for (int p = 0; p < PAD_COUNT; p++) begin
        if (st.captureSel[k*CAP_WIDTH +: CAP_WIDTH] == CAP_WIDTH'(p)) begin
          timerCapture[k] = irqBus.padSync[p];
        end
      end
    end
  end

  // Zero wait states: every access completes in its first access cycle.
  assign pready = 1'b1;
  assign prdata = st.readData;
  assign pslverr = psel & penable & st.readError;

endmodule // pcrb_top

// file: verification/pad_control_register_bank_tb_top.sv
// Self-checking bench for the pad control bank and its board.
`timescale 1ns/1ps
module pad_control_register_bank_tb_top;
  import pcrb_pkg::*;
  logic clk_sys = 1'h0;
  logic sys_rst = 1'h1;
  pcrb_addr_t paddr = '0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  pcrb_word_t pwdata = '0;
  pcrb_word_t prdata, r, s, c;
  logic pready, pslverr, irq;
  pcrb_pad_t padIn, padOut, padOutEnableN, padPullEnable, padHighDrive;
  pcrb_pad_t extEn = '1;
  pcrb_pad_t extVal = '0;
  logic [PAD_COUNT*FUNC_WIDTH-1:0] padFunction;
  logic [CAP_COUNT-1:0] timerCapture;
  logic [3:0] cfg;
  pcrb_word_t expQ[$];
  int numErrors = 0;
  int totalChecks = 0;
  localparam pcrb_addr_t ADR[5] = '{OFS_PULL_ENABLE, OFS_DRIVE_STRENGTH, OFS_CAPTURE_SEL, OFS_FUNC_LOW, OFS_FUNC_HIGH};
  localparam pcrb_word_t MSK[5] = '{32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'h77777777, 32'h07777777};
  // Interrupt setups on pad one: sense, both edges, polarity, starting level.
  localparam logic [3:0] CFG[4] = '{4'h1, 4'h2, 4'h4, 4'hA};

  pcrb_top i_dut (.clk_sys, .sys_rst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .padIn, .padOut, .padOutEnableN, .padPullEnable, .padHighDrive, .padFunction, .timerCapture, .irq);
  pcrb_board i_board (.clk_sys, .padOut, .padOutEnableN, .padPullEnable, .extEn, .extVal, .padIn);

  // The clock toggles every half period.
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic stopTest();
    if (numErrors == 0 && totalChecks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input pcrb_word_t v, input pcrb_word_t e);
    totalChecks++;
    if (v !== e) begin
      numErrors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, v, e);
    end
  endtask

  // One bus transfer, entered just after an edge; it leaves an idle edge so strobes never clash.
  task automatic apb(input pcrb_addr_t a, input logic w, input pcrb_word_t d);
    int n;
    n = 0;
    psel <= 1'h1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'h1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (pready !== 1'h1) begin
      numErrors++;
      stopTest();
    end
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk_sys);
  endtask

  task automatic wr(input pcrb_addr_t a, input pcrb_word_t d);
    apb(a, 1'h1, d);
  endtask

  task automatic rd(input pcrb_addr_t a, input pcrb_word_t e);
    expQ.push_back(e);
    apb(a, 1'h0, 32'h0);
  endtask

  // Read data is judged at the completing edge against the oldest note.
  always @(posedge clk_sys) begin
    // Only offset 0x034 is unmapped among the offsets this bench uses, so only it may raise an error.
    if (psel && penable && pready === 1'h1) begin
      chk({31'h0, pslverr}, {31'h0, paddr == 12'h034});
    end
    if (psel && penable && !pwrite && pready === 1'h1) begin
      if (expQ.size() == 0) chk(prdata, 32'hBAD0BAD0);
      else chk(prdata, expQ.pop_front());
    end
  end

  initial begin
    void'($urandom(1754));
    repeat (12) @(posedge clk_sys);
    sys_rst <= 1'h0;
    rd(OFS_DIRECTION, RST_ZERO);
    rd(OFS_PULL_ENABLE, RST_PULL_ENABLE);
    rd(OFS_DRIVE_STRENGTH, RST_ZERO);
    rd(OFS_FUNC_LOW, RST_ZERO);
    rd(OFS_FUNC_HIGH, RST_FUNC_HIGH);
    rd(OFS_CAPTURE_SEL, RST_ZERO);
    rd(OFS_IRQ_MASK, RST_ZERO);
    wr(OFS_MASKED_STATUS, 32'hFFFFFFFF);
    rd(OFS_MASKED_STATUS, RST_ZERO);
    rd(12'h034, RST_ZERO);
    // Random words read back whole; reserved function bits are kept at their default.
    for (int i = 0; i < 5; i++) begin
      r = $urandom() & MSK[i];
      wr(ADR[i], r);
      rd(ADR[i], r);
    end
    wr(OFS_FUNC_LOW, 32'h0);
    wr(OFS_FUNC_HIGH, 32'h0);
    wr(OFS_PULL_ENABLE, 32'h7FFF);
    // Driven pads read back through the synchroniser, then set and clear ports.
    r = $urandom();
    s = $urandom();
    c = $urandom();
    wr(OFS_DIRECTION, 32'h7FFF);
    wr(OFS_OUTPUT_DATA, r);
    repeat (3) @(posedge clk_sys);
    rd(OFS_OUTPUT_DATA, r & 32'h7FFF);
    wr(OFS_BIT_SET, s);
    wr(OFS_BIT_CLEAR, c);
    repeat (3) @(posedge clk_sys);
    rd(OFS_OUTPUT_DATA, (r | s) & ~c & 32'h7FFF);
    // Inputs: pads zero to seven driven from outside, the rest held by their pull.
    extVal <= s[14:0];
    extEn <= 15'h00FF;
    wr(OFS_DIRECTION, 32'h0);
    repeat (3) @(posedge clk_sys);
    rd(OFS_OUTPUT_DATA, (s & 32'hFF) | 32'h7F00);
    // Capture routing: pads two, three and ten, and one index past the last pad.
    wr(OFS_CAPTURE_SEL, 32'h0F0A0302);
    chk({28'h0, timerCapture}, {28'h0, 2'h1, s[3], s[2]});
    extEn <= 15'h7FFF;
    for (int m = 0; m < 4; m++) begin
      cfg = CFG[m];
      extVal <= {13'h0, cfg[0], 1'h0};
      repeat (4) @(posedge clk_sys);
      wr(OFS_SENSE_SELECT, {30'h0, cfg[3], 1'h0});
      wr(OFS_BOTH_EDGE, {30'h0, cfg[2], 1'h0});
      wr(OFS_POLARITY, {30'h0, cfg[1], 1'h0});
      wr(OFS_IRQ_CLEAR, 32'h7FFF);
      wr(OFS_IRQ_MASK, 32'h2);
      chk({31'h0, irq}, 32'h0);
      extVal <= {13'h0, !cfg[0], 1'h0};
      repeat (5) @(posedge clk_sys);
      chk({31'h0, irq}, 32'h1);
      rd(OFS_MASKED_STATUS, 32'h2);
      wr(OFS_IRQ_CLEAR, 32'h1);
      rd(OFS_MASKED_STATUS, 32'h2);
      wr(OFS_IRQ_CLEAR, 32'h2);
      rd(OFS_MASKED_STATUS, {30'h0, cfg[3], 1'h0});
      wr(OFS_IRQ_MASK, 32'h0);
      chk({31'h0, irq}, 32'h0);
    end
    stopTest();
  end
endmodule // pad_control_register_bank_tb_top

// file: verification/pcrb_asserts.sv
// Checker bound to the pad control bank's ports.
`timescale 1ns/1ps
module pcrb_asserts
  import pcrb_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire pcrb_pkg::pcrb_addr_t paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire pcrb_pkg::pcrb_word_t pwdata,
  input wire pcrb_pkg::pcrb_pad_t padOut,
  input wire pcrb_pkg::pcrb_pad_t padOutEnableN,
  input wire pcrb_pkg::pcrb_pad_t padPullEnable,
  input wire pcrb_pkg::pcrb_pad_t padHighDrive,
  input wire logic [pcrb_pkg::PAD_COUNT*pcrb_pkg::FUNC_WIDTH-1:0] padFunction,
  input wire logic irq
);
  pcrb_word_t lastData;
  // Every check uses the system clock; reset silences them all.
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  // Write data of the previous edge, so each check sees what was written.
  always_ff @(posedge clk_sys) begin
    lastData <= pwdata;
  end
  // A bus write that completes at this edge.
  sequence s_wr(pcrb_addr_t a);
    psel && penable && pwrite && paddr == a;
  endsequence
  AST_DATA_DRIVE: assert property (s_wr(OFS_OUTPUT_DATA) |=> padOut == lastData[14:0])
    else $error("output data not stored");
  AST_DIR_ENABLE: assert property (s_wr(OFS_DIRECTION) ##1 padFunction[2:0] == FUNC_GPIO |-> padOutEnableN[0] != lastData[0])
    else $error("direction not applied");
  AST_PULL: assert property (s_wr(OFS_PULL_ENABLE) |=> padPullEnable == lastData[14:0])
    else $error("pull enable not applied");
  AST_DRIVE: assert property (s_wr(OFS_DRIVE_STRENGTH) |=> padHighDrive == lastData[14:0])
    else $error("drive strength not applied");
  AST_FUNC_LOW: assert property (s_wr(OFS_FUNC_LOW) |=> padFunction[23:21] == lastData[30:28])
    else $error("low function field wrong");
  AST_FUNC_HIGH: assert property (s_wr(OFS_FUNC_HIGH) |=> padFunction[44:42] == lastData[26:24])
    else $error("high function field wrong");
  AST_SET_PORT: assert property (s_wr(OFS_BIT_SET) and pwdata[0] && padFunction[2:0] == FUNC_GPIO |=> padOut[0])
    else $error("set port failed");
  AST_CLR_PORT: assert property (s_wr(OFS_BIT_CLEAR) and pwdata[0] && padFunction[2:0] == FUNC_GPIO |=> !padOut[0])
    else $error("clear port failed");
  AST_MASK_BLOCK: assert property (s_wr(OFS_IRQ_MASK) and pwdata[14:0] == 15'h0 |=> !irq [*2])
    else $error("masked interrupt still raised");
endmodule // pcrb_asserts

bind pcrb_top pcrb_asserts i_asserts (.clk_sys(clk_sys), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .padOut(padOut), .padOutEnableN(padOutEnableN),
  .padPullEnable(padPullEnable), .padHighDrive(padHighDrive), .padFunction(padFunction), .irq(irq));

// file: verification/pcrb_board.sv
// Board model: outside drivers, pull resistors and floating pads.
`timescale 1ns/1ps
module pcrb_board
  import pcrb_pkg::*;
(
  input wire logic clk_sys,
  input wire pcrb_pkg::pcrb_pad_t padOut,
  input wire pcrb_pkg::pcrb_pad_t padOutEnableN,
  input wire pcrb_pkg::pcrb_pad_t padPullEnable,
  input wire pcrb_pkg::pcrb_pad_t extEn,
  input wire pcrb_pkg::pcrb_pad_t extVal,
  output pcrb_pkg::pcrb_pad_t padIn
);
  pcrb_pad_t lastLevel;
  // The block's driver beats the weak outside one; a floating pad flips so it never passes by luck.
  always_comb begin
    for (int i = 0; i < PAD_COUNT; i++) begin
      if (!padOutEnableN[i]) padIn[i] = padOut[i];
      else if (extEn[i]) padIn[i] = extVal[i];
      else if (padPullEnable[i]) padIn[i] = 1'h1;
      else padIn[i] = !lastLevel[i];
    end
  end
  // Remembers each pad's level for the floating case.
  always @(posedge clk_sys) begin
    lastLevel <= padIn;
  end
endmodule // pcrb_board
